// >>> hw/ddfe_cfg.svh
`ifndef DDFE_CFG_SVH
`define DDFE_CFG_SVH

// ----------------------------------------
// widths and depths
// ----------------------------------------
`define DDFE_BYTE_W      8
`define DDFE_SAMPLE_W    16
`define DDFE_FIFO_DEPTH  8
`define DDFE_FIFO_AW     3

// ----------------------------------------
// divider and codes
// ----------------------------------------
`define DDFE_DIV_ZERO    3'h0
`define DDFE_DIV_LAST    3'h3
`define DDFE_CODE_ZERO   16'h0000
`define DDFE_CODE_FULL   16'hffff
`define DDFE_REF_EXT     1'h1
`define DDFE_REF_INT_LVL 1'h1

`endif

// >>> hw/ddfe_pkg.sv
`include "ddfe_cfg.svh"

package ddfe_pkg;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic                    valid;
    logic                    frame;
    logic [`DDFE_BYTE_W-1:0] data;
  } ddfe_beat_type;

  typedef struct packed {
    logic [`DDFE_SAMPLE_W-1:0] a;
    logic [`DDFE_SAMPLE_W-1:0] b;
  } ddfe_pair_type;

  typedef enum logic [2:0] {
    ASM_WAIT,
    ASM_A_HI,
    ASM_A_LO,
    ASM_B_HI,
    ASM_B_LO
  } ddfe_asm_type;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic ddfe_diff(input logic p, input logic n);
    return p & ~n;
  endfunction

  function automatic logic ddfe_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// >>> hw/ddfe_capture.sv
`timescale 1ns/1ps
`include "ddfe_cfg.svh"

module ddfe_capture (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    clk_pos,
  input  wire logic                    clk_neg,
  input  wire logic                    frame_pos,
  input  wire logic                    frame_neg,
  input  wire logic [`DDFE_BYTE_W-1:0] data_pos,
  input  wire logic [`DDFE_BYTE_W-1:0] data_neg,
  input  wire logic                    bit_reverse,
  output ddfe_pkg::ddfe_beat_type      beat
);
  import ddfe_pkg::*;

  typedef struct packed {
    logic          dclk_prev;
    ddfe_beat_type beat;
  } ddfe_cap_state_type;

  ddfe_cap_state_type      st;
  ddfe_cap_state_type      next_st;
  logic [`DDFE_BYTE_W-1:0] lane;
  logic [`DDFE_BYTE_W-1:0] ordered;
  logic                    dclk;
  logic                    frame;

  // ----------------------------------------
  // lanes and order
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `DDFE_BYTE_W; i++)
    begin : g_lane
      assign lane[i]    = ddfe_diff(data_pos[i], data_neg[i]);
      assign ordered[i] = bit_reverse ? lane[`DDFE_BYTE_W-1-i] : lane[i]; // [RQ13] [RQ14]
    end
  endgenerate

  assign dclk  = ddfe_diff(clk_pos, clk_neg);
  assign frame = ddfe_diff(frame_pos, frame_neg);

  // ----------------------------------------
  // both edges, frame on rise
  // ----------------------------------------
  always_comb
  begin
    next_st            = st;
    next_st.dclk_prev  = dclk;
    next_st.beat.valid = dclk ^ st.dclk_prev;                  // [RQ1]
    next_st.beat.frame = ddfe_rise(dclk, st.dclk_prev) & frame; // [RQ2] [RQ4]
    next_st.beat.data  = ordered;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign beat = st.beat;

endmodule // ddfe_capture

// >>> hw/ddfe_fifo.sv
`timescale 1ns/1ps
`include "ddfe_cfg.svh"

module ddfe_fifo (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  flush,
  input  wire logic                  wr_valid,
  input  ddfe_pkg::ddfe_pair_type    wr_data,
  output logic                       wr_ready,
  input  wire logic                  rd_ready,
  output logic                       rd_valid,
  output ddfe_pkg::ddfe_pair_type    rd_data,
  output logic [`DDFE_FIFO_AW:0]     level
);
  import ddfe_pkg::*;

  typedef struct packed {
    ddfe_pair_type [`DDFE_FIFO_DEPTH-1:0] mem;
    logic [`DDFE_FIFO_AW:0]               wptr;
    logic [`DDFE_FIFO_AW:0]               rptr;
  } ddfe_fifo_state_type;

  ddfe_fifo_state_type st;
  ddfe_fifo_state_type next_st;
  logic                full;
  logic                empty;

  assign empty    = st.wptr == st.rptr;
  assign full     = (st.wptr[`DDFE_FIFO_AW-1:0] == st.rptr[`DDFE_FIFO_AW-1:0]) &&
                    (st.wptr[`DDFE_FIFO_AW] != st.rptr[`DDFE_FIFO_AW]);
  assign wr_ready = ~full;
  assign rd_valid = ~empty;
  assign rd_data  = st.mem[st.rptr[`DDFE_FIFO_AW-1:0]];
  assign level    = st.wptr - st.rptr;

  always_comb
  begin
    next_st = st;
    if (flush)
    begin
      next_st.wptr = '0; // [RQ3]
      next_st.rptr = '0; // [RQ3]
    end
    else
    begin
      if (wr_valid && !full)
      begin
        next_st.mem[st.wptr[`DDFE_FIFO_AW-1:0]] = wr_data;
        next_st.wptr = st.wptr + 1'b1;
      end
      if (rd_ready && !empty)
        next_st.rptr = st.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

endmodule // ddfe_fifo

// >>> hw/ddfe_front_end.sv
// Notes on behaviour
// RQ1: bus bytes are taken on both edges of the data clock, two per period.
// RQ2: the frame marker is sampled on data clock rises only and opens a frame.
// RQ3: a captured frame marker resets the FIFO pointers.
// RQ4: the source launches the frame marker edge-aligned with the data bits.
// RQ5: the sync strobe is sampled on converter clock rises, not data clock.
// RQ6: a captured sync strobe resets the clock divider for multi-device alignment.
// RQ7: data reaches the datapath only while the transmit gate is high.
// RQ8: with the gate low, codes are all zero and arriving data is dropped.
// RQ9: codes are offset binary; zero is full primary sink, all ones is none.
// RQ10: reference select high takes the pin as input, low drives internal ref out.
// RQ11: the serial select is active low, host driven, and only an input here.
// RQ12: the serial data line is bidirectional in three-pin and four-pin modes.
// RQ13: bus bit seven is the most significant bit unless order is reversed.
// RQ14: a config bit reverses the bus bit order before byte assembly.
// RQ15: after a frame, bytes go A high, A low, B high, B low into one FIFO word.
`timescale 1ns/1ps
`include "ddfe_cfg.svh"

module ddfe_front_end (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     src_sync_clock_pos,
  input  wire logic                     src_sync_clock_neg,
  input  wire logic                     frame_marker_pos,
  input  wire logic                     frame_marker_neg,
  input  wire logic [`DDFE_BYTE_W-1:0]  bus_data_pos,
  input  wire logic [`DDFE_BYTE_W-1:0]  bus_data_neg,
  input  wire logic                     bus_bit_reverse,
  input  wire logic                     converter_clock,
  input  wire logic                     sync_strobe_pos,
  input  wire logic                     sync_strobe_neg,
  input  wire logic                     transmit_gate,
  input  wire logic                     ref_ext_enable,
  input  wire logic                     reference_pin_in,
  output logic                          reference_pin_out,
  output logic                          reference_pin_oe,
  output logic                          reference_in_use,
  input  wire logic                     serial_select_n,
  input  wire logic                     serial_read_phase,
  input  wire logic                     serial_tx_bit,
  input  wire logic                     serial_data_in,
  output logic                          serial_data_out,
  output logic                          serial_data_oe,
  output logic                          serial_rx_bit,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_a_code,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_b_code,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_a_primary_out,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_a_complement_out,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_b_primary_out,
  output logic [`DDFE_SAMPLE_W-1:0]     chan_b_complement_out,
  output logic [2:0]                    divider_phase,
  output logic                          sync_pulse,
  output logic                          frame_seen,
  output logic                          fifo_overflow,
  output logic                          fifo_underflow,
  output logic [`DDFE_FIFO_AW:0]        fifo_level
);
  import ddfe_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ddfe_asm_type              asm_st;
    logic [`DDFE_BYTE_W-1:0]   hi_byte;
    logic [`DDFE_SAMPLE_W-1:0] a_hold;
    ddfe_pair_type             push_pair;
    logic                      push;
    logic                      conv_prev;
    logic [2:0]                div_cnt;
    logic [`DDFE_SAMPLE_W-1:0] code_a;
    logic [`DDFE_SAMPLE_W-1:0] code_b;
    logic [`DDFE_SAMPLE_W-1:0] prim_a;
    logic [`DDFE_SAMPLE_W-1:0] comp_a;
    logic [`DDFE_SAMPLE_W-1:0] prim_b;
    logic [`DDFE_SAMPLE_W-1:0] comp_b;
    logic                      sync_pulse;
    logic                      frame_seen;
    logic                      overflow;
    logic                      underflow;
    logic                      ref_oe;
    logic                      ref_in_use;
    logic                      sdo;
    logic                      sdo_oe;
    logic                      sdi;
  } ddfe_top_state_type;

  ddfe_top_state_type st;
  ddfe_top_state_type next_st;

  ddfe_beat_type      beat;
  ddfe_pair_type      fifo_rd_data;
  logic               fifo_wr_ready;
  logic               fifo_rd_valid;
  logic               fifo_rd_ready;
  logic               fifo_flush;
  logic               conv_rise;
  logic               sync_strobe;
  logic               pop_slot;

  // ----------------------------------------
  // capture
  // ----------------------------------------
  ddfe_capture u_capture (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .clk_pos     (src_sync_clock_pos),
    .clk_neg     (src_sync_clock_neg),
    .frame_pos   (frame_marker_pos),
    .frame_neg   (frame_marker_neg),
    .data_pos    (bus_data_pos),
    .data_neg    (bus_data_neg),
    .bit_reverse (bus_bit_reverse),
    .beat        (beat)
  );

  // ----------------------------------------
  // sample fifo
  // ----------------------------------------
  assign fifo_flush = (beat.valid && beat.frame) || !transmit_gate; // [RQ3] [RQ8]

  ddfe_fifo u_fifo (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .flush    (fifo_flush),
    .wr_valid (st.push),
    .wr_data  (st.push_pair),
    .wr_ready (fifo_wr_ready),
    .rd_ready (fifo_rd_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .level    (fifo_level)
  );

  // ----------------------------------------
  // converter clock domain decode
  // ----------------------------------------
  assign conv_rise     = ddfe_rise(converter_clock, st.conv_prev);
  assign sync_strobe   = ddfe_diff(sync_strobe_pos, sync_strobe_neg);
  assign pop_slot      = conv_rise && !sync_strobe && (st.div_cnt == `DDFE_DIV_LAST);
  assign fifo_rd_ready = pop_slot && transmit_gate; // [RQ7]

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st            = st;
    next_st.push       = 1'b0;
    next_st.sync_pulse = 1'b0;
    next_st.overflow   = 1'b0;
    next_st.underflow  = 1'b0;
    next_st.conv_prev  = converter_clock;

    // byte assembly
    if (!transmit_gate)
    begin
      next_st.asm_st     = ASM_WAIT; // [RQ8]
      next_st.frame_seen = 1'b0;
    end
    else if (beat.valid)
    begin
      if (beat.frame)
      begin
        next_st.hi_byte    = beat.data; // [RQ15]
        next_st.asm_st     = ASM_A_LO;
        next_st.frame_seen = 1'b1;
      end
      else
      begin
        case (st.asm_st)
          ASM_WAIT:
            next_st.asm_st = ASM_WAIT;
          ASM_A_HI:
          begin
            next_st.hi_byte = beat.data; // [RQ15]
            next_st.asm_st  = ASM_A_LO;
          end
          ASM_A_LO:
          begin
            next_st.a_hold = {st.hi_byte, beat.data}; // [RQ13] [RQ15]
            next_st.asm_st = ASM_B_HI;
          end
          ASM_B_HI:
          begin
            next_st.hi_byte = beat.data;
            next_st.asm_st  = ASM_B_LO;
          end
          ASM_B_LO:
          begin
            next_st.push_pair.a = st.a_hold; // [RQ15]
            next_st.push_pair.b = {st.hi_byte, beat.data};
            next_st.push        = 1'b1; // [RQ7]
            next_st.asm_st      = ASM_A_HI;
          end
          default:
            next_st.asm_st = ASM_WAIT;
        endcase
      end
    end

    if (st.push && !fifo_wr_ready && !fifo_flush)
      next_st.overflow = 1'b1;

    // divider, strobe on converter rise
    if (conv_rise)
    begin
      if (sync_strobe)
      begin
        next_st.div_cnt    = `DDFE_DIV_ZERO; // [RQ5] [RQ6]
        next_st.sync_pulse = 1'b1;
      end
      else if (st.div_cnt == `DDFE_DIV_LAST)
        next_st.div_cnt = `DDFE_DIV_ZERO;
      else
        next_st.div_cnt = st.div_cnt + 3'h1;
    end

    // datapath codes
    if (!transmit_gate)
    begin
      next_st.code_a = `DDFE_CODE_ZERO; // [RQ8]
      next_st.code_b = `DDFE_CODE_ZERO; // [RQ8]
    end
    else if (pop_slot)
    begin
      if (fifo_rd_valid)
      begin
        next_st.code_a = fifo_rd_data.a; // [RQ7]
        next_st.code_b = fifo_rd_data.b;
      end
      else
        next_st.underflow = 1'b1;
    end

    // offset binary sink levels
    next_st.prim_a = `DDFE_CODE_FULL - next_st.code_a; // [RQ9]
    next_st.comp_a = next_st.code_a; // [RQ9]
    next_st.prim_b = `DDFE_CODE_FULL - next_st.code_b; // [RQ9]
    next_st.comp_b = next_st.code_b; // [RQ9]

    // reference source
    next_st.ref_oe     = ref_ext_enable != `DDFE_REF_EXT; // [RQ10]
    next_st.ref_in_use = (ref_ext_enable == `DDFE_REF_EXT) ? reference_pin_in : `DDFE_REF_INT_LVL; // [RQ10]

    // serial data pin, select only sensed
    next_st.sdo_oe = !serial_select_n && serial_read_phase; // [RQ11] [RQ12]
    next_st.sdo    = serial_tx_bit;
    if (!serial_select_n && !serial_read_phase)
      next_st.sdi = serial_data_in; // [RQ12]
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign chan_a_code           = st.code_a;
  assign chan_b_code           = st.code_b;
  assign chan_a_primary_out    = st.prim_a;
  assign chan_a_complement_out = st.comp_a;
  assign chan_b_primary_out    = st.prim_b;
  assign chan_b_complement_out = st.comp_b;
  assign divider_phase         = st.div_cnt;
  assign sync_pulse            = st.sync_pulse;
  assign frame_seen            = st.frame_seen;
  assign fifo_overflow         = st.overflow;
  assign fifo_underflow        = st.underflow;
  assign reference_pin_out     = `DDFE_REF_INT_LVL;
  assign reference_pin_oe      = st.ref_oe;
  assign reference_in_use      = st.ref_in_use;
  assign serial_data_out       = st.sdo;
  assign serial_data_oe        = st.sdo_oe;
  assign serial_rx_bit         = st.sdi;

endmodule // ddfe_front_end

// >>> dv/ddfe_front_end_chk.sv
`timescale 1ns/1ps

module ddfe_front_end_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        converter_clock,
  input wire logic        sync_strobe_pos,
  input wire logic        sync_strobe_neg,
  input wire logic        transmit_gate,
  input wire logic        ref_ext_enable,
  input wire logic        reference_pin_out,
  input wire logic        reference_pin_oe,
  input wire logic        serial_select_n,
  input wire logic        serial_read_phase,
  input wire logic        serial_data_oe,
  input wire logic [15:0] chan_a_code,
  input wire logic [15:0] chan_a_primary_out,
  input wire logic [15:0] chan_a_complement_out,
  input wire logic [2:0]  divider_phase,
  input wire logic        sync_pulse,
  input wire logic        frame_seen,
  input wire logic [3:0]  fifo_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wire logic strobe;
  assign strobe = sync_strobe_pos & ~sync_strobe_neg;

  // ----------------
  // assertions
  // ----------------
  AST_REF_PIN:
    assert property (!$past(rst) && $past(ce) && $stable(ref_ext_enable)
                     |-> reference_pin_oe == !ref_ext_enable && reference_pin_out)
    else $error("reference pin direction wrong");
  AST_SEL_IN:
    assert property (ce && serial_select_n |=> !serial_data_oe)
    else $error("serial line driven while deselected");
  AST_SDIO_DIR:
    assert property (ce && !serial_select_n && serial_read_phase |=> serial_data_oe)
    else $error("serial line not driven in read phase");
  AST_GATE_ZERO:
    assert property (ce && !transmit_gate |=> chan_a_code == 16'h0000 && chan_a_primary_out == 16'hffff)
    else $error("codes not forced to zero");
  AST_GATE_FLUSH:
    assert property (ce && !transmit_gate |=> fifo_level == 4'h0 && !frame_seen)
    else $error("data kept while gate low");
  AST_OFFSET:
    assert property ($changed(chan_a_code) |-> chan_a_primary_out == ~chan_a_code && chan_a_complement_out == chan_a_code)
    else $error("output pair not offset binary");
  AST_SYNC:
    assert property (ce && $rose(converter_clock) && strobe |-> ##1 divider_phase == 3'h0 ##[0:1] sync_pulse)
    else $error("strobe did not reset divider");
  AST_DIV_HOLD:
    assert property (!$past(rst) && !$rose(converter_clock) |=> $stable(divider_phase))
    else $error("divider moved without converter clock rise");

  cover property ($rose(converter_clock) && strobe);
  cover property (fifo_level == 4'h8);
  cover property ($fell(transmit_gate));
endmodule // ddfe_front_end_chk

bind ddfe_front_end ddfe_front_end_chk chk (
  .clk, .rst, .ce, .converter_clock, .sync_strobe_pos, .sync_strobe_neg, .transmit_gate, .ref_ext_enable,
  .reference_pin_out, .reference_pin_oe, .serial_select_n, .serial_read_phase, .serial_data_oe, .chan_a_code,
  .chan_a_primary_out, .chan_a_complement_out, .divider_phase, .sync_pulse, .frame_seen, .fifo_level
);

// >>> dv/ddfe_src_model.sv
`timescale 1ns/1ps

module ddfe_src_model (
  input  wire logic clk,
  output logic       src_sync_clock_pos,
  output logic       src_sync_clock_neg,
  output logic       frame_marker_pos,
  output logic       frame_marker_neg,
  output logic [7:0] bus_data_pos,
  output logic [7:0] bus_data_neg
);
  logic       dclk = 1'h0;
  logic       frm = 1'h0;
  logic [7:0] dat = 8'h00;

  assign src_sync_clock_pos = dclk;
  assign src_sync_clock_neg = ~dclk;
  assign frame_marker_pos   = frm;
  assign frame_marker_neg   = ~frm;
  assign bus_data_pos       = dat;
  assign bus_data_neg       = ~dat;

  // ----------------
  // one pair, clock still between pairs
  // ----------------
  task automatic send_pair(input logic [15:0] a, input logic [15:0] b, input logic fr);
    logic [31:0] w;
    w = {a, b};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      #1;
      dclk = ~dclk;
      frm  = fr && (i == 0);
      dat  = w[31 - 8 * i -: 8];
      @(posedge clk);
    end
    #1;
    frm = 1'h0;
    dat = ~dat;
  endtask
endmodule // ddfe_src_model

// >>> dv/test_ddfe_front_end.sv
`timescale 1ns/1ps

module test_ddfe_front_end;
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             ce = 1'h1;
  logic             rev, conv, sp, gate, ref_ext, ref_in, sel_n, rd_ph, tx_bit, sd_in, rx_e;
  int               ovf_cnt = 0;
  wire logic        dcp, dcn, fmp, fmn, ref_out, ref_oe, ref_use, sd_out, sd_oe, rx_bit, sync_p, fr_seen, ovf, unf;
  wire logic [7:0]  dp, dn;
  wire logic [15:0] ca, cb, pa, qa, pb, qb;
  wire logic [2:0]  div;
  wire logic [3:0]  lvl;
  logic [31:0]      rng = 32'h0000_469c;
  logic [31:0]      exp_c;
  logic [31:0]      q[$];
  logic [2:0]       dv_m;
  int               err_total = 0;
  int               tests_run = 0;

  always #4 clk = ~clk;

  always @(posedge clk)
    if (ovf)
      ovf_cnt++;

  ddfe_src_model src (.clk(clk), .src_sync_clock_pos(dcp), .src_sync_clock_neg(dcn), .frame_marker_pos(fmp),
                      .frame_marker_neg(fmn), .bus_data_pos(dp), .bus_data_neg(dn));

  ddfe_front_end uut (
    .clk(clk), .rst(rst), .ce(ce), .src_sync_clock_pos(dcp), .src_sync_clock_neg(dcn), .frame_marker_pos(fmp),
    .frame_marker_neg(fmn), .bus_data_pos(dp), .bus_data_neg(dn), .bus_bit_reverse(rev), .converter_clock(conv),
    .sync_strobe_pos(sp), .sync_strobe_neg(~sp), .transmit_gate(gate), .ref_ext_enable(ref_ext),
    .reference_pin_in(ref_in), .reference_pin_out(ref_out), .reference_pin_oe(ref_oe), .reference_in_use(ref_use),
    .serial_select_n(sel_n), .serial_read_phase(rd_ph), .serial_tx_bit(tx_bit), .serial_data_in(sd_in),
    .serial_data_out(sd_out), .serial_data_oe(sd_oe), .serial_rx_bit(rx_bit), .chan_a_code(ca), .chan_b_code(cb),
    .chan_a_primary_out(pa), .chan_a_complement_out(qa), .chan_b_primary_out(pb), .chan_b_complement_out(qb),
    .divider_phase(div), .sync_pulse(sync_p), .frame_seen(fr_seen), .fifo_overflow(ovf),
    .fifo_underflow(unf), .fifo_level(lvl));

  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] o;
    for (int i = 0; i < 8; i++)
      o[i] = rev ? v[7 - i] : v[i];
    return o;
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic push(input logic fr);
    logic [31:0] w;
    w = rnd();
    src.send_pair(w[31:16], w[15:0], fr);
    if (fr)
      q.delete();
    if (gate && q.size() < 8)
      q.push_back({rev8(w[31:24]), rev8(w[23:16]), rev8(w[15:8]), rev8(w[7:0])});
  endtask

  task automatic tick(input logic st);
    logic pop;
    logic unf_e;
    logic s;
    logic u;
    @(posedge clk);
    #1;
    conv  = 1'h1;
    sp    = st;
    pop   = !st && dv_m == 3'h3;
    unf_e = pop && q.size() == 0;
    dv_m  = (st || pop) ? 3'h0 : dv_m + 3'h1;
    if (pop && !unf_e)
      exp_c = q.pop_front();
    @(posedge clk);
    #1;
    s    = sync_p;
    u    = unf;
    conv = 1'h0;
    sp   = 1'h0;
    @(posedge clk);
    #1;
    s = s | sync_p;
    check("sync", st, s);
    check("divider", dv_m, div);
    check("underflow", unf_e, u);
    check("codes", exp_c, {ca, cb});
    check("sink", ~exp_c, {pa, pb});
    check("mirror", exp_c, {qa, qb});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end

  // ----------------
  // sequence
  // ----------------
  initial
  begin
    logic [31:0] r;
    int          n;
    {rev, conv, sp, gate, ref_ext, ref_in, rd_ph, tx_bit, sd_in, rx_e} = '0;
    sel_n = 1'h1;
    exp_c = '0;
    dv_m  = '0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'h0;
    check("codes", '0, {ca, cb});
    check("sink", '0, {pa, pb});
    check("level", 32'h1, {lvl, div, ref_out});
    push(1'h1);
    repeat (4) @(posedge clk);
    #1;
    check("level", '0, lvl);
    check("frame", '0, fr_seen);
    $display("test reset and gate low done");
    for (int t = 0; t < 6; t++)
    begin
      gate = 1'h1;
      rev  = t[0];
      sp   = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      sp = 1'h0;
      check("divider", dv_m, div);
      tick(1'h1);
      n = rnd() % 6;
      push(1'h1);
      repeat (n) push(1'h0);
      if (t[1])
        push(1'h1);
      repeat (4) @(posedge clk);
      #1;
      check("level", q.size(), lvl);
      check("frame", 32'h1, fr_seen);
      repeat (4 * q.size() + 4) tick(1'h0);
      gate  = 1'h0;
      exp_c = '0;
      @(posedge clk);
      #1;
      check("codes", exp_c, {ca, cb});
      check("level", '0, lvl);
      $display("test stream %0d done", t);
    end
    gate = 1'h1;
    n    = ovf_cnt;
    push(1'h1);
    repeat (8) push(1'h0);
    repeat (4) @(posedge clk);
    #1;
    check("overflow", 32'h1, ovf_cnt - n);
    check("level", q.size(), lvl);
    repeat (40) tick(1'h0);
    $display("test full fifo done");
    repeat (16)
    begin
      r = rnd();
      {ref_ext, ref_in, sel_n, rd_ph, tx_bit, sd_in} = r[5:0];
      if (!r[3] && !r[2])
        rx_e = r[0];
      @(posedge clk);
      #1;
      check("ref oe", !r[5], ref_oe);
      check("ref use", r[5] ? r[4] : 1'h1, ref_use);
      check("sdio oe", !r[3] && r[2], sd_oe);
      check("sdio out", r[1], sd_out);
      check("sdio in", rx_e, rx_bit);
    end
    ce      = 1'h0;
    ref_ext = ~ref_ext;
    repeat (2) @(posedge clk);
    #1;
    check("ce hold", !r[5], ref_oe);
    ce = 1'h1;
    $display("test pins done");
    wrap_up();
  end
endmodule // test_ddfe_front_end
